// ==== core/amp_pin_sync.sv ====
// three-stage synchroniser for a bus of pin inputs
`timescale 1ns/1ns
module amp_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_i,
  input  wire logic         reset_n_i,
  input  wire logic         clk_en_i,
  input  wire logic [W-1:0] pin_i,
  input  wire logic [W-1:0] rst_val_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // ==========================================================
  // chain; first stage only feeds the second
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      meta <= rst_val_i;
      s2   <= rst_val_i;
      s3   <= rst_val_i;
    end else if (clk_en_i) begin
      meta <= pin_i;
      s2   <= meta;
      s3   <= s2;
    end
  end

  // ==========================================================
  // output follows only where stages two and three agree
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
          sync_o[g] <= rst_val_i[g];
        end else if (clk_en_i && (s2[g] == s3[g])) begin
          sync_o[g] <= s3[g];
        end
      end
    end
  endgenerate
endmodule

// ==== core/amp_pkg.sv ====
// package of constants for the asynchronous external memory pin port
// Function
// - drive access address on pins 23..0
// - address pins 15..8 shareable: flags, waveform
// - reset puts address pins in memory mode
// - reset leaves flag pins 0..3 as inputs
// - parallel input samples address pins 23..4
// - data pins carry data or flags 7..0
// - low acknowledge stretches the current access
// - one active-low select per bank 0, 1
// - bank select decoded, switches with address
// - selects high when no access runs
// - false conditional access leaves selects inactive
// - read strobe asserted for each word read
// - write strobe asserted for each word written
// - bank select one serves flash boot
package amp_pkg;
  // ==========================================================
  // widths
  localparam int ADDR_W      = 24;
  localparam int DATA_W      = 16;
  localparam int BANK_SEL_W  = 2;
  localparam int BANK_ALL_W  = 4;
  localparam int FLAG_HI_W   = 8;
  localparam int FLAG_LO_W   = 8;
  localparam int GP_W        = 4;
  localparam int PIN_IN_LSB  = 4;
  localparam int PIN_IN_W    = ADDR_W - PIN_IN_LSB;
  localparam int BANK_MSB    = 23;
  localparam int BANK_LSB    = 22;
  localparam int FLAG_HI_LSB = 8;
  localparam int PWM_W       = 8;
  // ==========================================================
  // pin function selects
  localparam logic [1:0] ADDR_MODE_MEM  = 2'h0;
  localparam logic [1:0] ADDR_MODE_FLAG = 2'h1;
  localparam logic [1:0] ADDR_MODE_PWM  = 2'h2;
  localparam logic [1:0] GP_MODE_FLAG   = 2'h0;
  localparam logic [1:0] GP_MODE_IRQ    = 2'h1;
  localparam logic [1:0] GP_MODE_SEL    = 2'h2;
  localparam logic [1:0] GP_MODE_TIMER  = 2'h3;
  // ==========================================================
  // reset values
  localparam logic [ADDR_W-1:0]     ADDR_RST  = 24'h000000;
  localparam logic [DATA_W-1:0]     DATA_RST  = 16'h0000;
  localparam logic [BANK_ALL_W-1:0] SEL_IDLE  = 4'hf;
  localparam logic [1:0]            SYNC_ZERO = 2'h0;
  // strobe floor: ack and read data need the pin synchroniser latency
  localparam logic [2:0]            STB_MIN   = 3'h4;
  // ==========================================================
  // access sequencer states, gray along idle-setup-strobe-hold
  typedef enum logic [1:0] {
    AMP_IDLE   = 2'b00,
    AMP_SETUP  = 2'b01,
    AMP_STROBE = 2'b11,
    AMP_HOLD   = 2'b10
  } amp_state_e;
endpackage

// ==== core/amp_port.sv ====
// asynchronous external memory pin port top
`timescale 1ns/1ns
module amp_port
  import amp_pkg::*;
(
  input  wire logic                          sys_clk_i,
  input  wire logic                          reset_n_i,
  input  wire logic                          clk_en_i,
  // access request from the core side
  input  wire logic                          req_valid_i,
  input  wire logic                          req_write_i,
  input  wire logic                          req_cond_i,
  input  wire logic [amp_pkg::ADDR_W-1:0]    req_addr_i,
  input  wire logic [amp_pkg::DATA_W-1:0]    req_wdata_i,
  input  wire logic                          boot_flash_i,
  output logic                               req_ready_o,
  output logic                               rsp_valid_o,
  output logic [amp_pkg::DATA_W-1:0]         rsp_rdata_o,
  // pin function configuration
  input  wire logic [1:0]                    addr_mode_i,
  input  wire logic                          data_flag_en_i,
  input  wire logic                          parallel_input_ctrl_i,
  input  wire logic [1:0]                    gp_mode2_i,
  input  wire logic [1:0]                    gp_mode3_i,
  input  wire logic [1:0]                    gp_mode01_i,
  // alternate function sources and sinks
  input  wire logic [amp_pkg::FLAG_HI_W-1:0] flag_hi_out_i,
  input  wire logic [amp_pkg::FLAG_HI_W-1:0] flag_hi_oe_i,
  input  wire logic [amp_pkg::PWM_W-1:0]     pwm_i,
  input  wire logic [amp_pkg::FLAG_LO_W-1:0] flag_lo_out_i,
  input  wire logic [amp_pkg::FLAG_LO_W-1:0] flag_lo_oe_i,
  input  wire logic [amp_pkg::GP_W-1:0]      gp_out_i,
  input  wire logic [amp_pkg::GP_W-1:0]      gp_oe_i,
  input  wire logic                          timer_expired_out,
  output logic [amp_pkg::FLAG_HI_W-1:0]      flag_hi_in_o,
  output logic [amp_pkg::FLAG_LO_W-1:0]      flag_lo_in_o,
  output logic [amp_pkg::GP_W-1:0]           gp_in_o,
  output logic [amp_pkg::GP_W-1:0]           irq_req_o,
  output logic [amp_pkg::PIN_IN_W-1:0]       parallel_input_channel_o,
  // pins
  input  wire logic [amp_pkg::ADDR_W-1:0]    addr_pin_i,
  output logic [amp_pkg::ADDR_W-1:0]         addr_pin_o,
  output logic [amp_pkg::ADDR_W-1:0]         addr_pin_oe_o,
  input  wire logic [amp_pkg::DATA_W-1:0]    data_pin_i,
  output logic [amp_pkg::DATA_W-1:0]         data_pin_o,
  output logic [amp_pkg::DATA_W-1:0]         data_pin_oe_o,
  input  wire logic                          ext_access_ack_n,
  output logic [amp_pkg::BANK_SEL_W-1:0]     bank_select_n,
  output logic                               ext_read_strobe_n,
  output logic                               ext_write_strobe_n,
  input  wire logic                          gp_pin0_irq_i,
  input  wire logic                          gp_pin1_irq_i,
  input  wire logic                          gp_pin2_irq_sel_i,
  input  wire logic                          gp_pin3_timer_sel_i,
  output logic                               gp_pin2_irq_sel_o,
  output logic                               gp_pin2_irq_sel_oe_o,
  output logic                               gp_pin3_timer_sel_o,
  output logic                               gp_pin3_timer_sel_oe_o
);
  import amp_pkg::*;

  amp_state_e                state;
  logic [ADDR_W-1:0]         acc_addr;
  logic [DATA_W-1:0]         acc_wdata;
  logic                      acc_write;
  logic                      acc_live;
  logic                      acc_boot;
  logic [BANK_ALL_W-1:0]     sel_n;
  logic                      ack_sync;
  logic [ADDR_W-1:0]         addr_sync;
  logic [DATA_W-1:0]         data_sync;
  logic [GP_W-1:0]           gp_sync;
  logic [GP_W-1:0]           gp_pins;
  logic [1:0]                gp_mode [GP_W];
  logic [2:0]                stb_cnt;
  logic                      stb_done;
  logic                      take;
  logic [BANK_ALL_W-1:0]     next_sel_n;

  // ack is only trusted once the synchroniser has seen the strobe
  assign stb_done = (stb_cnt == STB_MIN) && ack_sync;
  assign take     = (state == AMP_IDLE) && req_valid_i && req_cond_i;

  // ==========================================================
  // bank decode from the top address bits, used only for the select drive
  function automatic logic [BANK_ALL_W-1:0] bank_decode(input logic [ADDR_W-1:0] a,
                                                        input logic boot);
    logic [BANK_ALL_W-1:0] s;
    s = SEL_IDLE;
    if (boot) begin
      s[1] = 1'b0;
    end else begin
      s[a[BANK_MSB:BANK_LSB]] = 1'b0;
    end
    return s;
  endfunction

  // ==========================================================
  // pin synchronisers
  amp_pin_sync #(.W(1)) u_sync_ack (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .clk_en_i  (clk_en_i),
    .pin_i     (ext_access_ack_n),
    .rst_val_i (1'b1),
    .sync_o    (ack_sync)
  );
  amp_pin_sync #(.W(ADDR_W)) u_sync_addr (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .clk_en_i  (clk_en_i),
    .pin_i     (addr_pin_i),
    .rst_val_i (ADDR_RST),
    .sync_o    (addr_sync)
  );
  amp_pin_sync #(.W(DATA_W)) u_sync_data (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .clk_en_i  (clk_en_i),
    .pin_i     (data_pin_i),
    .rst_val_i (DATA_RST),
    .sync_o    (data_sync)
  );
  assign gp_pins = {gp_pin3_timer_sel_i, gp_pin2_irq_sel_i, gp_pin1_irq_i, gp_pin0_irq_i};
  amp_pin_sync #(.W(GP_W)) u_sync_gp (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .clk_en_i  (clk_en_i),
    .pin_i     (gp_pins),
    .rst_val_i (4'h0),
    .sync_o    (gp_sync)
  );

  // ==========================================================
  // access sequencer: setup, strobe until ack high, hold
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      state   <= AMP_IDLE;
      stb_cnt <= '0;
    end else if (clk_en_i) begin
      if (state != AMP_STROBE) begin
        stb_cnt <= '0;
      end else if (stb_cnt != STB_MIN) begin
        stb_cnt <= stb_cnt + 3'h1;
      end
      unique case (state)
        AMP_IDLE: begin
          if (req_valid_i && req_cond_i) begin
            state <= AMP_SETUP;
          end
        end
        AMP_SETUP: begin
          state <= AMP_STROBE;
        end
        AMP_STROBE: begin
          if (stb_done) begin
            state <= AMP_HOLD;
          end
        end
        AMP_HOLD: begin
          state <= AMP_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // latch the request; a false condition is consumed without pins
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      acc_addr  <= ADDR_RST;
      acc_wdata <= DATA_RST;
      acc_write <= 1'b0;
      acc_boot  <= 1'b0;
    end else if (clk_en_i && state == AMP_IDLE && req_valid_i && req_cond_i) begin
      acc_addr  <= req_addr_i;
      acc_wdata <= req_wdata_i;
      acc_write <= req_write_i;
      acc_boot  <= boot_flash_i;
    end
  end

  assign acc_live    = (state != AMP_IDLE);
  assign req_ready_o = (state == AMP_IDLE);

  // ==========================================================
  // next selects, shared by bank pins and gp pins so all switch together
  always_comb begin
    next_sel_n = sel_n;
    if (take) begin
      next_sel_n = bank_decode(req_addr_i, boot_flash_i);
    end else if (state == AMP_HOLD) begin
      next_sel_n = SEL_IDLE;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      sel_n <= SEL_IDLE;
    end else if (clk_en_i) begin
      sel_n <= next_sel_n;
    end
  end
  assign bank_select_n = sel_n[BANK_SEL_W-1:0];

  // ==========================================================
  // strobes low only in the strobe state, never both
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      ext_read_strobe_n  <= 1'b1;
      ext_write_strobe_n <= 1'b1;
    end else if (clk_en_i) begin
      ext_read_strobe_n  <= !((state == AMP_SETUP || (state == AMP_STROBE && !stb_done)) && !acc_write);
      ext_write_strobe_n <= !((state == AMP_SETUP || (state == AMP_STROBE && !stb_done)) && acc_write);
    end
  end

  // ==========================================================
  // read data captured at the end of the strobe
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= DATA_RST;
    end else if (clk_en_i) begin
      rsp_valid_o <= (state == AMP_HOLD);
      if (state == AMP_STROBE && stb_done && !acc_write) begin
        rsp_rdata_o <= data_sync;
      end
    end
  end

  // ==========================================================
  // address pins: memory, flags or pwm; parallel input overrides drive
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      addr_pin_o    <= ADDR_RST;
      addr_pin_oe_o <= '1;
    end else if (clk_en_i) begin
      addr_pin_o    <= take ? req_addr_i : acc_addr;
      addr_pin_oe_o <= '1;
      unique case (addr_mode_i)
        ADDR_MODE_FLAG: begin
          addr_pin_o[FLAG_HI_LSB+:FLAG_HI_W]    <= flag_hi_out_i;
          addr_pin_oe_o[FLAG_HI_LSB+:FLAG_HI_W] <= flag_hi_oe_i;
        end
        ADDR_MODE_PWM: begin
          addr_pin_o[FLAG_HI_LSB+:FLAG_HI_W]    <= pwm_i;
        end
        default: begin
        end
      endcase
      if (parallel_input_ctrl_i) begin
        addr_pin_oe_o[ADDR_W-1:PIN_IN_LSB] <= '0;
      end
    end
  end

  // ==========================================================
  // captured inputs from the address and data pins
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      parallel_input_channel_o <= '0;
      flag_hi_in_o             <= '0;
      flag_lo_in_o             <= '0;
    end else if (clk_en_i) begin
      if (parallel_input_ctrl_i) begin
        parallel_input_channel_o <= addr_sync[ADDR_W-1:PIN_IN_LSB];
      end
      flag_hi_in_o <= addr_sync[FLAG_HI_LSB+:FLAG_HI_W];
      flag_lo_in_o <= data_sync[FLAG_LO_W-1:0];
    end
  end

  // ==========================================================
  // data pins: write data during writes, or flags 7..0
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      data_pin_o    <= DATA_RST;
      data_pin_oe_o <= '0;
    end else if (clk_en_i) begin
      data_pin_o    <= acc_wdata;
      data_pin_oe_o <= {DATA_W{acc_live && acc_write}};
      if (data_flag_en_i) begin
        data_pin_o[FLAG_LO_W-1:0]    <= flag_lo_out_i;
        data_pin_oe_o[FLAG_LO_W-1:0] <= flag_lo_oe_i;
      end
    end
  end

  // ==========================================================
  // low general pins; mode 0 after reset is flag input
  assign gp_mode[0] = gp_mode01_i;
  assign gp_mode[1] = gp_mode01_i;
  assign gp_mode[2] = gp_mode2_i;
  assign gp_mode[3] = gp_mode3_i;

  genvar gi;
  generate
    for (gi = 0; gi < GP_W; gi++) begin : g_gp
      always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
          gp_in_o[gi]   <= 1'b0;
          irq_req_o[gi] <= 1'b0;
        end else if (clk_en_i) begin
          gp_in_o[gi]   <= gp_sync[gi];
          irq_req_o[gi] <= (gp_mode[gi] == GP_MODE_IRQ) && (gi < 3) && gp_sync[gi];
        end
      end
    end
  endgenerate

  // ==========================================================
  // pins 2 and 3 outputs; reset value keeps them undriven inputs
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      gp_pin2_irq_sel_o      <= 1'b1;
      gp_pin2_irq_sel_oe_o   <= 1'b0;
      gp_pin3_timer_sel_o    <= 1'b1;
      gp_pin3_timer_sel_oe_o <= 1'b0;
    end else if (clk_en_i) begin
      unique case (gp_mode2_i)
        GP_MODE_SEL: begin
          gp_pin2_irq_sel_o    <= next_sel_n[2];
          gp_pin2_irq_sel_oe_o <= 1'b1;
        end
        GP_MODE_FLAG: begin
          gp_pin2_irq_sel_o    <= gp_out_i[2];
          gp_pin2_irq_sel_oe_o <= gp_oe_i[2];
        end
        default: begin
          gp_pin2_irq_sel_o    <= 1'b1;
          gp_pin2_irq_sel_oe_o <= 1'b0;
        end
      endcase
      unique case (gp_mode3_i)
        GP_MODE_SEL: begin
          gp_pin3_timer_sel_o    <= next_sel_n[3];
          gp_pin3_timer_sel_oe_o <= 1'b1;
        end
        GP_MODE_TIMER: begin
          gp_pin3_timer_sel_o    <= timer_expired_out;
          gp_pin3_timer_sel_oe_o <= 1'b1;
        end
        GP_MODE_FLAG: begin
          gp_pin3_timer_sel_o    <= gp_out_i[3];
          gp_pin3_timer_sel_oe_o <= gp_oe_i[3];
        end
        default: begin
          gp_pin3_timer_sel_o    <= 1'b1;
          gp_pin3_timer_sel_oe_o <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ==== verif/amp_mem_model.sv ====
// external asynchronous memory model behind the pin port, with optional wait states
`timescale 1ns/1ns
module amp_mem_model (
  input  wire logic        sys_clk_i,
  input  wire logic        slow_i,
  input  wire logic [7:0]  wait_i,
  input  wire logic [23:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic [1:0]  sel_n_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  output logic      [15:0] rdata_o,
  output logic             ack_n_o
);
  logic [15:0] mem [256];
  logic [7:0]  cnt;
  wire         act = (sel_n_i != 2'h3) && !(rd_n_i && wr_n_i);
  // count strobe cycles and store written words; only the low address byte is decoded
  always @(posedge sys_clk_i) begin
    cnt <= act ? cnt + 8'h1 : 8'h0;
    if (act && !wr_n_i) begin
      mem[addr_i[7:0]] <= wdata_i;
    end
  end
  // a slow device holds ack low until its wait has run out
  assign ack_n_o = slow_i ? !(act && cnt < wait_i) : 1'b1;
  // released data lines float to the pull-up level
  assign rdata_o = (act && !rd_n_i) ? mem[addr_i[7:0]] : 16'hffff;
endmodule

// ==== verif/amp_port_properties.sv ====
// pin-level property checker bound to the external memory pin port
`timescale 1ns/1ns
module amp_port_props
  import amp_pkg::*;
(
  input wire logic                        sys_clk_i,
  input wire logic                        reset_n_i,
  input wire logic                        clk_en_i,
  input wire logic                        req_valid_i,
  input wire logic                        req_write_i,
  input wire logic                        req_cond_i,
  input wire logic [amp_pkg::ADDR_W-1:0]  req_addr_i,
  input wire logic                        boot_flash_i,
  input wire logic                        req_ready_o,
  input wire logic                        parallel_input_ctrl_i,
  input wire logic [amp_pkg::ADDR_W-1:0]  addr_pin_o,
  input wire logic [amp_pkg::ADDR_W-1:0]  addr_pin_oe_o,
  input wire logic [amp_pkg::DATA_W-1:0]  data_pin_oe_o,
  input wire logic                        ext_access_ack_n,
  input wire logic [amp_pkg::BANK_SEL_W-1:0] bank_select_n,
  input wire logic                        ext_read_strobe_n,
  input wire logic                        ext_write_strobe_n,
  input wire logic                        gp_pin2_irq_sel_oe_o,
  input wire logic                        gp_pin3_timer_sel_oe_o
);
  default clocking dcb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // a taken access with a true condition, and any strobe low
  wire take = clk_en_i && req_valid_i && req_ready_o && req_cond_i;
  wire act  = !(ext_read_strobe_n && ext_write_strobe_n);
  // ==========================================================
  // access framing
  idle_pins_a: assert property (req_ready_o |-> bank_select_n == 2'h3 && !act)
    else $error("select or strobe active while idle");
  strobe_excl_a: assert property (!(!ext_read_strobe_n && !ext_write_strobe_n))
    else $error("both strobes low");
  bank_dec_a: assert property (take && !boot_flash_i && !req_addr_i[23] |=>
    bank_select_n == ($past(req_addr_i[22]) ? 2'h1 : 2'h2) && addr_pin_o == $past(req_addr_i))
    else $error("bank select or address wrong");
  boot_sel_a: assert property (take && boot_flash_i |=> bank_select_n == 2'h1)
    else $error("boot access not on select one");
  false_cond_a: assert property (req_valid_i && req_ready_o && !req_cond_i |=> req_ready_o && bank_select_n == 2'h3)
    else $error("false condition started an access");
  rd_strobe_a: assert property (take && !req_write_i |-> ##2 !ext_read_strobe_n)
    else $error("read strobe missing");
  wr_strobe_a: assert property (take && req_write_i |-> ##2 data_pin_oe_o == 16'hffff && !ext_write_strobe_n)
    else $error("write strobe or data drive missing");
  ack_stretch_a: assert property (!ext_access_ack_n [*5] ##0 act |=> act)
    else $error("access ended while ack low");
  pin_input_a: assert property (parallel_input_ctrl_i |=> addr_pin_oe_o[23:4] == 20'h0)
    else $error("address pins driven during parallel input");
  reset_pins_a: assert property (disable iff (1'b0) !reset_n_i |=> addr_pin_oe_o == 24'hffffff &&
    data_pin_oe_o == 16'h0 && bank_select_n == 2'h3 && !gp_pin2_irq_sel_oe_o && !gp_pin3_timer_sel_oe_o)
    else $error("pin state after reset wrong");
  // main scenarios reached
  cover property (take && !req_write_i ##2 !ext_read_strobe_n);
  cover property (take && req_write_i);
  cover property (!ext_access_ack_n && act);
endmodule
bind amp_port amp_port_props amp_port_props_i (.*);

// ==== verif/async_ext_memory_pin_port_tb.sv ====
// self-checking bench for the external memory pin port
`timescale 1ns/1ns
module async_ext_memory_pin_port_tb;
  import amp_pkg::*;
  logic        sys_clk_i, reset_n_i, clk_en_i, req_valid_i, req_write_i, req_cond_i, boot_flash_i;
  logic        req_ready_o, rsp_valid_o, data_flag_en_i, parallel_input_ctrl_i, timer_expired_out, slow;
  logic        ext_read_strobe_n, ext_write_strobe_n, gp_pin2_irq_sel_o, gp_pin2_irq_sel_oe_o;
  logic        gp_pin3_timer_sel_o, gp_pin3_timer_sel_oe_o;
  logic [1:0]  addr_mode_i, gp_mode2_i, gp_mode3_i, gp_mode01_i, bank_select_n;
  logic [3:0]  gp_out_i, gp_oe_i, gp_in_o, irq_req_o, gp_drv;
  logic [7:0]  flag_hi_out_i, flag_hi_oe_i, pwm_i, flag_lo_out_i, flag_lo_oe_i, flag_hi_in_o, flag_lo_in_o, wait_cyc;
  logic [15:0] req_wdata_i, rsp_rdata_o, data_pin_o, data_pin_oe_o, mem_q;
  logic [19:0] parallel_input_channel_o;
  logic [23:0] req_addr_i, addr_pin_o, addr_pin_oe_o, addr_drv;
  wire  [15:0] data_pin_i;
  wire  [23:0] addr_pin_i;
  wire         ext_access_ack_n, gp_pin0_irq_i, gp_pin1_irq_i, gp_pin2_irq_sel_i, gp_pin3_timer_sel_i;
  int          fail_count, total_checks, cyc;
  // ==========================================================
  // pin levels: an enabled driver wins, else the far side or the pull-up
  assign data_pin_i          = (data_pin_oe_o & data_pin_o) | (~data_pin_oe_o & mem_q);
  assign addr_pin_i          = (addr_pin_oe_o & addr_pin_o) | (~addr_pin_oe_o & addr_drv);
  assign gp_pin0_irq_i       = gp_drv[0];
  assign gp_pin1_irq_i       = gp_drv[1];
  assign gp_pin2_irq_sel_i   = gp_pin2_irq_sel_oe_o ? gp_pin2_irq_sel_o : gp_drv[2];
  assign gp_pin3_timer_sel_i = gp_pin3_timer_sel_oe_o ? gp_pin3_timer_sel_o : gp_drv[3];
  amp_port amp_port_i (.*);
  amp_mem_model amp_mem_model_i (.sys_clk_i(sys_clk_i), .slow_i(slow), .wait_i(wait_cyc), .addr_i(addr_pin_o),
    .wdata_i(data_pin_i), .sel_n_i(bank_select_n), .rd_n_i(ext_read_strobe_n), .wr_n_i(ext_write_strobe_n),
    .rdata_o(mem_q), .ack_n_o(ext_access_ack_n));
  always #20 sys_clk_i = ~sys_clk_i;
  // watchdog, so a hung handshake still reaches the verdict
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fail_count = fail_count + 1;
      close_out();
    end
  end
  // ==========================================================
  // helpers
  task automatic close_out();
    if (fail_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask
  // flags are keep-valid, write, condition, boot; returns at the taking edge
  task automatic issue(input logic [3:0] f, input logic [23:0] a, input logic [15:0] d);
    int n = 0;
    {req_valid_i, req_write_i, req_cond_i, boot_flash_i} <= {1'b1, f[2:0]};
    req_addr_i <= a;
    req_wdata_i <= d;
    do begin
      @(negedge sys_clk_i);
      n++;
    end while (!req_ready_o && n < 40);
    @(posedge sys_clk_i);
    if (!f[3]) begin
      req_valid_i <= 1'b0;
    end
  endtask
  task automatic wait_rsp(output logic [15:0] q, output int n);
    n = 0;
    do begin
      @(negedge sys_clk_i);
      n++;
    end while (rsp_valid_o !== 1'b1 && n < 40);
    q = rsp_rdata_o;
    @(posedge sys_clk_i);
  endtask
  task automatic rd(input logic [23:0] a, input logic boot, output logic [15:0] q, output int n);
    issue({3'b001, boot}, a, 16'h0);
    wait_rsp(q, n);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    tick(5);
    chk(addr_pin_oe_o, 24'hffffff);
    chk(24'({bank_select_n, ext_read_strobe_n, ext_write_strobe_n, gp_pin2_irq_sel_oe_o,
             gp_pin3_timer_sel_oe_o, gp_in_o}), 24'h3c5);
    chk(24'(data_pin_oe_o), 24'h0);
    @(posedge sys_clk_i);
  endtask
  task automatic rw_one(input logic [23:0] a, input logic [15:0] d, input logic [1:0] sel);
    logic [15:0] q;
    int n;
    issue(4'h6, a, d);
    @(negedge sys_clk_i);
    chk(24'(bank_select_n), 24'(sel));
    chk(addr_pin_o, a);
    wait_rsp(q, n);
    rd(a, 1'b0, q, n);
    chk(24'(q), 24'(d));
  endtask
  // back-to-back writes: the second is taken in the answer cycle of the first
  task automatic t_b2b();
    logic [15:0] q;
    int n;
    issue(4'he, 24'h000056, 16'h1234);
    issue(4'h6, 24'h000057, 16'h4321);
    wait_rsp(q, n);
    chk(24'(n), 24'h8);
    rd(24'h000056, 1'b0, q, n);
    chk(24'(q), 24'h1234);
    rd(24'h000057, 1'b0, q, n);
    chk(24'(q), 24'h4321);
  endtask
  task automatic t_cond();
    logic [15:0] q;
    int n;
    issue(4'h4, 24'h000012, 16'hdead);
    repeat (6) begin
      @(negedge sys_clk_i);
      chk({21'h0, bank_select_n, ext_write_strobe_n}, 24'h7);
    end
    @(posedge sys_clk_i);
    rd(24'h000012, 1'b0, q, n);
    chk(24'(q), 24'ha5c3);
  endtask
  task automatic t_boot();
    logic [15:0] q;
    int n;
    issue(4'h3, 24'h000012, 16'h0);
    @(negedge sys_clk_i);
    chk(24'(bank_select_n), 24'h1);
    wait_rsp(q, n);
    chk(24'(q), 24'ha5c3);
  endtask
  // slow device: ack goes low with the strobe for long enough for the synchroniser to see it
  task automatic t_slow();
    logic [15:0] q;
    int n;
    {slow, wait_cyc} <= 9'h106;
    repeat (5) @(posedge sys_clk_i);
    rd(24'h400013, 1'b0, q, n);
    chk(24'(n), 24'he);
    chk(24'(q), 24'h5a3c);
    slow <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
  endtask
  task automatic t_bank2();
    logic [15:0] q;
    int n;
    gp_mode2_i <= GP_MODE_SEL;
    @(posedge sys_clk_i);
    issue(4'h6, 24'h800020, 16'h0f0f);
    @(negedge sys_clk_i);
    chk(24'({gp_pin2_irq_sel_oe_o, gp_pin2_irq_sel_o, bank_select_n}), 24'hb);
    wait_rsp(q, n);
    gp_mode2_i <= GP_MODE_FLAG;
  endtask
  task automatic t_pins();
    {addr_mode_i, pwm_i, flag_hi_out_i, flag_hi_oe_i} <= {ADDR_MODE_PWM, 24'h5ac33c};
    tick(3);
    chk(addr_pin_oe_o, 24'hffffff);
    chk(24'(addr_pin_o[15:8]), 24'h5a);
    @(posedge sys_clk_i);
    addr_mode_i <= ADDR_MODE_FLAG;
    tick(2);
    chk(24'({addr_pin_oe_o[15:8], addr_pin_o[15:8]}), 24'h3cc3);
    @(posedge sys_clk_i);
    {addr_mode_i, parallel_input_ctrl_i, data_flag_en_i, addr_drv} <= {ADDR_MODE_MEM, 2'h3, 24'habcde7};
    {flag_lo_out_i, flag_lo_oe_i} <= 16'h3cf0;
    {gp_mode01_i, gp_mode3_i, gp_out_i, gp_oe_i, gp_drv, timer_expired_out} <= {GP_MODE_IRQ, GP_MODE_TIMER, 13'h08b};
    tick(6);
    chk(24'(addr_pin_oe_o[23:4]), 24'h0);
    chk(24'(parallel_input_channel_o), 24'habcde);
    chk({data_pin_oe_o[7:0], data_pin_o[7:0], flag_lo_in_o}, 24'hf03c3f);
    chk(24'({irq_req_o[1:0], gp_pin2_irq_sel_oe_o, gp_pin2_irq_sel_o, gp_pin3_timer_sel_oe_o,
             gp_pin3_timer_sel_o}), 24'h1b);
    @(posedge sys_clk_i);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    sys_clk_i = 1'b0;
    reset_n_i = 1'b0;
    {clk_en_i, req_valid_i, req_write_i, req_cond_i, boot_flash_i, data_flag_en_i, parallel_input_ctrl_i} = 7'h40;
    {addr_mode_i, gp_mode2_i, gp_mode3_i, gp_mode01_i} = 8'h0;
    {flag_hi_out_i, flag_hi_oe_i, pwm_i, flag_lo_out_i, flag_lo_oe_i} = 40'h0;
    {gp_out_i, gp_oe_i, gp_drv, timer_expired_out, slow, wait_cyc} = 22'h01400;
    {req_addr_i, req_wdata_i, addr_drv} = {40'h0, 24'hffffff};
    {fail_count, total_checks, cyc} = {32'h0, 32'h0, 32'h0};
    repeat (3) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    rw_one(24'h000012, 16'ha5c3, 2'h2);
    rw_one(24'h400013, 16'h5a3c, 2'h1);
    t_b2b();
    t_cond();
    t_boot();
    t_slow();
    t_bank2();
    t_pins();
    close_out();
  end
endmodule
